/* File: testbench/cmtc_chk.sv */
// port assertions for the mailbox transmit control
`timescale 1ns/10ps
module cmtc_chk import cmtc_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // engine side and status
   input wire cmtc_req_t tx_req,
   input wire logic comm_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // read data only in the cycle after a read strobe
   a_rdata_quiet: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside read cycle");
   a_unmapped_zero: assert property (rd && addr > 4'h8 |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   // one frame in flight, so issues never crowd each other
   a_req_spacing: assert property (tx_req.valid |=> !tx_req.valid ##1 !tx_req.valid)
      else $error("issue pulse too long or too close");
   a_req_run_only: assert property (tx_req.valid |-> comm_enable || $past(comm_enable))
      else $error("frame issued outside run state");
   a_run_enable: assert property (wr && addr == 4'h0 && wdata[1:0] == 2'b00 |=> ##[0:1] comm_enable)
      else $error("run state not entered");
   a_halt_stop: assert property (wr && addr == 4'h0 && wdata[1] |=> ##[0:1] !comm_enable)
      else $error("halt did not stop communication");
   a_reset_stop: assert property (wr && addr == 4'h0 && wdata[0] |=> ##[0:1] !comm_enable)
      else $error("reset state did not stop communication");
   a_reset_quiet: assert property (!$past(rst_n) |-> !comm_enable && !tx_req.valid)
      else $error("activity right after reset");
endmodule
bind cmtc_top cmtc_chk u_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .tx_req(tx_req), .comm_enable(comm_enable));

/* File: testbench/cmtc_engine_model.sv */
// protocol engine model answering each issued frame
`timescale 1ns/10ps
module cmtc_engine_model import cmtc_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // request and scenario controls
   input wire cmtc_req_t tx_req,
   input wire logic [1:0] outcome,
   input wire logic [7:0] delay,
   // outcome pulses
   output logic tx_start,
   output logic tx_success,
   output logic tx_arb_lost,
   output logic tx_bus_error,
   output logic bus_idle,
   output int n_issue
);
   logic [1:0] oc;
   // outcome 3: frame sent on an idle bus, no arbitration pulse
   assign bus_idle = (outcome == 2'd3);
   // outcome latched at issue; a losing node never starts
   initial begin
      {tx_start, tx_success, tx_arb_lost, tx_bus_error} = '0;
      n_issue = 0;
      forever begin
         @(posedge clk);
         if (rst_n && tx_req.valid) begin
            n_issue++;
            oc = outcome;
            repeat (delay) @(posedge clk);
            if (oc != 2'd1 && oc != 2'd3) begin
               tx_start <= 1'b1;
               @(posedge clk);
               tx_start <= 1'b0;
               repeat (delay) @(posedge clk);
            end
            tx_success <= (oc == 2'd0 || oc == 2'd3);
            tx_arb_lost <= (oc == 2'd1);
            tx_bus_error <= (oc == 2'd2);
            @(posedge clk);
            {tx_success, tx_arb_lost, tx_bus_error} <= 3'b000;
         end
      end
   end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench of the mailbox transmit control
`timescale 1ns/10ps
`include "cmtc_cfg.svh"
module testbench import cmtc_pkg::*;;
   logic clk, rst_n, ce, wr, rd, tx_start, tx_success, tx_arb_lost, tx_bus_error, bus_idle;
   logic comm_enable, irq;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, r;
   logic [1:0] outcome;
   logic [7:0] delay;
   cmtc_req_t tx_req;
   int n_issue, k, n_mismatch, samples_checked;
   cmtc_top u_cmtc_top (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .tx_req(tx_req), .tx_start(tx_start), .tx_success(tx_success),
      .tx_arb_lost(tx_arb_lost), .tx_bus_error(tx_bus_error), .bus_idle(bus_idle),
      .comm_enable(comm_enable), .irq(irq));
   cmtc_engine_model u_cmtc_engine_model (.clk(clk), .rst_n(rst_n), .tx_req(tx_req), .outcome(outcome),
      .delay(delay), .tx_start(tx_start), .tx_success(tx_success), .tx_arb_lost(tx_arb_lost),
      .tx_bus_error(tx_bus_error), .bus_idle(bus_idle), .n_issue(n_issue));
   // 100 MHz clock
   always #5 clk = ~clk;
   // comparison and bus tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      r = rdata;
   endtask
   task automatic rbit(input logic [3:0] a, input int b, input logic e);
      rreg(a);
      check({31'h0, r[b]}, {31'h0, e});
   endtask
   task automatic go(input logic [3:0] mb, input logic [31:0] ctl);
      k = n_issue;
      wreg(4'h4, {28'h0, mb});
      rreg(4'h5);
      check(r, 32'h0);
      wreg(4'h5, ctl);
   endtask
   // bounded waits on the engine model; settle then adds a fixed 30 cycles
   task automatic waitn(input int n);
      repeat (300) if (n_issue < n) @(posedge clk);
      check(n_issue, n);
   endtask
   task automatic settle;
      repeat (300) if (!(tx_success || tx_arb_lost || tx_bus_error)) @(posedge clk);
      repeat (30) @(posedge clk);
   endtask
   task automatic chk_irq(input logic e);
      repeat (3) @(posedge clk);
      #1;
      check({31'h0, irq}, {31'h0, e});
   endtask
   task automatic t_normal;
      rreg(4'h0);
      check(r, `CMTC_CTRL_RESET_VAL);
      rreg(4'hf);
      check(r, 32'h0);
      wreg(4'h0, 32'h0); // leaves reset state for run state before the setup
      go(4'd3, 32'h1);
      settle;
      rbit(4'h6, 3, 1'b1);
      rbit(4'h7, 3, 1'b0);
      chk_irq(1'b1);
      wreg(4'h3, 32'h7);
      chk_irq(1'b0);
      wreg(4'h3, 32'h0);
      chk_irq(1'b1);
      wreg(4'h2, 32'h7);
      chk_irq(1'b0);
      // both selects set is refused and never issued
      go(4'd8, 32'h3);
      repeat (30) @(posedge clk);
      check(n_issue, k);
      rreg(4'h5);
      check(r, 32'h0);
      // first attempt loses, the retry must follow without software
      outcome <= 2'd1;
      go(4'd5, 32'h1);
      waitn(k + 1);
      outcome <= 2'd0;
      waitn(k + 2);
      settle;
      rbit(4'h6, 5, 1'b1);
      // a frame started on an idle bus counts as won
      outcome <= 2'd3;
      go(4'd7, 32'h1);
      settle;
      rbit(4'h6, 7, 1'b1);
      outcome <= 2'd0;
   endtask
   // one-shot with success, lost arbitration and bus error, the last mailbox included
   task automatic t_single_attempt_enable;
      for (int i = 0; i < 3; i++) begin
         outcome <= i[1:0];
         wreg(4'h2, 32'h7);
         go(4'(13 + i), 32'h5);
         settle;
         check(n_issue, k + 1);
         rbit(4'h6, 13 + i, i == 0);
         rbit(4'h7, 13 + i, i != 0);
         rbit(4'h2, 0, i == 0);
      end
   endtask
   // abort while halted, then after the frame has started
   task automatic t_abort;
      wreg(4'h0, 32'h2);
      go(4'd2, 32'h1);
      wreg(4'h5, 32'h0);
      rbit(4'h7, 2, 1'b1);
      rreg(4'h4);
      check(r, 32'h2);
      wreg(4'h0, 32'h0);
      repeat (30) @(posedge clk);
      check(n_issue, k);
      delay <= 8'd10;
      for (int j = 0; j < 2; j++) begin
         outcome <= j ? 2'd0 : 2'd2;
         go(4'(4 + 2 * j), 32'h1);
         repeat (300) if (!tx_start) @(posedge clk);
         wreg(4'h5, 32'h0);
         settle;
         check(n_issue, k + 1);
         rbit(4'h7, 4 + 2 * j, j == 0);
         rbit(4'h6, 4 + 2 * j, j == 1);
      end
      wreg(4'h0, 32'h1);
      rbit(4'h6, 3, 1'b0);
      rreg(4'h4);
      check(r, 32'h0);
      check({31'h0, comm_enable}, 32'h0);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // main sequence after a 12-cycle reset
   initial begin
      {clk, rst_n, ce, wr, rd, addr, wdata, outcome} = '0;
      ce = 1'b1;
      delay = 8'd2;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_normal;
      t_single_attempt_enable;
      t_abort;
      print_verdict;
   end
   // watchdog against a hang
   initial begin
      #300000;
      n_mismatch++;
      print_verdict;
   end
endmodule

/* File: verilog/cmtc_cfg.svh */
// constants of the can mailbox transmit control block
`ifndef CMTC_CFG_SVH
`define CMTC_CFG_SVH
`define CMTC_NUM_MB 16
`define CMTC_ADDR_CTRL 4'h0
`define CMTC_ADDR_STAT 4'h1
`define CMTC_ADDR_IST 4'h2
`define CMTC_ADDR_IMASK 4'h3
`define CMTC_ADDR_MBSEL 4'h4
`define CMTC_ADDR_MBCTL 4'h5
`define CMTC_ADDR_DONE 4'h6
`define CMTC_ADDR_ABT 4'h7
`define CMTC_ADDR_BUSY 4'h8
`define CMTC_CTRL_RESET_BIT 0
`define CMTC_CTRL_HALT_BIT 1
`define CMTC_CTRL_RESET_VAL 32'h0000_0001
`define CMTC_MB_TX_BIT 0
`define CMTC_MB_RX_BIT 1
`define CMTC_MB_SINGLE_ATTEMPT_ENABLE_BIT 2
`define CMTC_MB_DONE_BIT 3
`define CMTC_MB_ABT_BIT 4
`define CMTC_IRQ_DONE_BIT 0
`define CMTC_IRQ_ERR_BIT 1
`define CMTC_IRQ_ABT_BIT 2
`endif

/* File: verilog/cmtc_mb_mem.sv */
// mailbox control memory, registered read port
`timescale 1ns/10ps
module cmtc_mb_mem import cmtc_pkg::*; #(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   // clocking
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // synchronous clear of every slot
   input wire logic clr,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire cmtc_mb_t wdata,
   // read port
   input wire logic [AW-1:0] raddr,
   output cmtc_mb_t rdata
);
   cmtc_mb_t mem [DEPTH];

   // storage, one generate slot per mailbox
   for (genvar i = 0; i < DEPTH; i++) begin : g_slot
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            mem[i] <= '0;
         end else if (ce) begin
            if (clr) begin
               mem[i] <= '0;
            end else if (we && waddr == AW'(i)) begin
               mem[i] <= wdata;
            end
         end
      end
   end

   // read data from a register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= mem[raddr];
      end
   end
endmodule

/* File: verilog/cmtc_pkg.sv */
// types of the can mailbox transmit control block
package cmtc_pkg;
   typedef enum logic [1:0] {
      CMTC_OP_RESET,
      CMTC_OP_HALT,
      CMTC_OP_RUN
   } cmtc_op_t;
   // one mailbox control slot
   typedef struct packed {
      logic abort_done;
      logic tx_done;
      logic single_attempt_enable;
      logic rx_mailbox_select;
      logic tx_mailbox_select;
   } cmtc_mb_t;
   // frame request to the protocol engine
   typedef struct packed {
      logic valid;
      logic [3:0] mailbox;
   } cmtc_req_t;
   // frame outcome from the protocol engine
   typedef struct packed {
      logic started;
      logic success;
      logic arb_lost;
      logic bus_error;
   } cmtc_res_t;
endpackage

/* File: verilog/cmtc_top.sv */
// transmit-side mailbox control of a single-channel can controller
`timescale 1ns/10ps
`include "cmtc_cfg.svh"
module cmtc_top import cmtc_pkg::*; #(
   parameter int NUM_MB = `CMTC_NUM_MB
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // register port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // protocol engine side
   output cmtc_req_t tx_req,
   input wire logic tx_start,
   input wire logic tx_success,
   input wire logic tx_arb_lost,
   input wire logic tx_bus_error,
   input wire logic bus_idle,
   // status
   output logic comm_enable,
   output logic irq
);
   localparam int AW = $clog2(NUM_MB);

   // operating state and control register
   cmtc_op_t op_reg;
   logic [31:0] ctrl_reg;
   logic [NUM_MB-1:0] tx_sel_reg, rx_sel_reg, one_reg, done_reg, abt_reg;
   logic [NUM_MB-1:0] busy_reg;      // abort requested but not finished
   logic [NUM_MB-1:0] abt_set;       // abort flag raised this cycle
   logic [AW-1:0] mbsel_reg;
   logic [2:0] ist_reg, imask_reg;
   logic active_reg;                 // a frame is on the bus
   logic [AW-1:0] cur_reg;
   logic won_reg;                    // arbitration won or idle start
   cmtc_res_t res;
   cmtc_mb_t mem_rd, mem_wd;
   logic mem_we;

   // outcome of the engine bundled together
   assign res = '{started: tx_start, success: tx_success, arb_lost: tx_arb_lost, bus_error: tx_bus_error};

   wire in_reset = (op_reg == CMTC_OP_RESET);
   wire running = (op_reg == CMTC_OP_RUN);
   wire ctl_wr = wr && addr == `CMTC_ADDR_CTRL;
   wire mb_wr = wr && addr == `CMTC_ADDR_MBCTL;
   wire fail = res.arb_lost | res.bus_error;

   // operating state follows the control register bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= `CMTC_CTRL_RESET_VAL;
         op_reg <= CMTC_OP_RESET;
      end else if (ce) begin
         if (ctl_wr) begin
            ctrl_reg <= {30'h0, wdata[1:0]};
            if (wdata[`CMTC_CTRL_RESET_BIT]) begin
               op_reg <= CMTC_OP_RESET;
            end else if (wdata[`CMTC_CTRL_HALT_BIT]) begin
               op_reg <= CMTC_OP_HALT;   // settings kept
            end else begin
               op_reg <= CMTC_OP_RUN;
            end
         end
      end
   end

   // communication may proceed only in run state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         comm_enable <= 1'b0;
      end else if (ce) begin
         comm_enable <= running;
      end
   end

   // mailbox selection for the indirect control byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mbsel_reg <= '0;
      end else if (ce) begin
         if (in_reset) begin
            mbsel_reg <= '0;
         end else if (wr && addr == `CMTC_ADDR_MBSEL) begin
            mbsel_reg <= wdata[AW-1:0];
         end
      end
   end

   // per-mailbox control and flags, one slot per mailbox
   for (genvar i = 0; i < NUM_MB; i++) begin : g_mb
      wire sel = mb_wr && mbsel_reg == AW'(i);
      wire mine = active_reg && cur_reg == AW'(i);
      wire ok = mine && res.success && won_reg;
      wire bad = mine && fail;
      wire clr_tx = sel && !wdata[`CMTC_MB_TX_BIT];
      // abort of a frame that is not in flight to the engine
      wire early_abt = busy_reg[i] && !mine && tx_sel_reg[i] == 1'b0;
      assign abt_set[i] = early_abt || (bad && (busy_reg[i] || one_reg[i]));
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            tx_sel_reg[i] <= 1'b0;
            rx_sel_reg[i] <= 1'b0;
            one_reg[i] <= 1'b0;
            done_reg[i] <= 1'b0;
            abt_reg[i] <= 1'b0;
            busy_reg[i] <= 1'b0;
         end else if (ce) begin
            if (in_reset) begin
               tx_sel_reg[i] <= 1'b0;
               rx_sel_reg[i] <= 1'b0;
               one_reg[i] <= 1'b0;
               done_reg[i] <= 1'b0;
               abt_reg[i] <= 1'b0;
               busy_reg[i] <= 1'b0;
            end else begin
               // software writes the control byte; both selects refused
               if (sel && !(wdata[`CMTC_MB_TX_BIT] && wdata[`CMTC_MB_RX_BIT])) begin
                  tx_sel_reg[i] <= wdata[`CMTC_MB_TX_BIT];
                  rx_sel_reg[i] <= wdata[`CMTC_MB_RX_BIT];
                  one_reg[i] <= wdata[`CMTC_MB_SINGLE_ATTEMPT_ENABLE_BIT];
               end
               // clearing tx select on a pending mailbox starts an abort
               // a frame that succeeds in the same cycle is not aborted
               if (clr_tx && tx_sel_reg[i] && !ok) begin
                  busy_reg[i] <= 1'b1;
               end else if (early_abt || ok || bad) begin
                  busy_reg[i] <= 1'b0;
               end
               // hardware ends the request on success or one-shot failure
               if (ok || (bad && one_reg[i])) begin
                  tx_sel_reg[i] <= 1'b0;
               end
               // done flag: set beats a software clear
               if (ok) begin
                  done_reg[i] <= 1'b1;
               end else if (sel && !wdata[`CMTC_MB_DONE_BIT]) begin
                  done_reg[i] <= 1'b0;
               end
               // abort flag, never on a successful frame
               if (early_abt) begin
                  abt_reg[i] <= 1'b1;
               end else if (bad && (busy_reg[i] || one_reg[i])) begin
                  abt_reg[i] <= 1'b1;
               end else if (sel && !wdata[`CMTC_MB_ABT_BIT]) begin
                  abt_reg[i] <= 1'b0;
               end
            end
         end
      end
   end

   // pick the lowest pending mailbox; a retry leaves it pending
   logic [AW-1:0] pick;
   logic pick_ok;
   always_comb begin
      pick = '0;
      pick_ok = 1'b0;
      for (int j = NUM_MB - 1; j >= 0; j--) begin
         if (tx_sel_reg[j] && !busy_reg[j]) begin
            pick = AW'(j);
            pick_ok = 1'b1;
         end
      end
   end

   // frame engine handshake; halt stops issuing new frames
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_reg <= 1'b0;
         cur_reg <= '0;
         won_reg <= 1'b0;
         tx_req <= '0;
      end else if (ce) begin
         if (in_reset) begin
            active_reg <= 1'b0;
            tx_req <= '0;
         end else if (active_reg) begin
            tx_req.valid <= 1'b0;
            if (res.started) begin
               won_reg <= 1'b1;
            end
            if (res.success || fail) begin
               active_reg <= 1'b0;   // loss ends our driving, retry later
               won_reg <= 1'b0;
            end
         end else if (running && pick_ok) begin
            active_reg <= 1'b1;
            cur_reg <= pick;
            won_reg <= bus_idle;
            tx_req <= '{valid: 1'b1, mailbox: pick};
         end else begin
            tx_req.valid <= 1'b0;
         end
      end
   end

   // sticky interrupt status, write one to clear, set wins
   logic any_ok, any_bad, any_abt;
   assign any_ok = active_reg && res.success && won_reg;
   assign any_bad = active_reg && fail;
   assign any_abt = |abt_set;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ist_reg <= '0;
         imask_reg <= '0;
      end else if (ce) begin
         if (in_reset) begin
            ist_reg <= '0;
            imask_reg <= '0;
         end else begin
            if (wr && addr == `CMTC_ADDR_IMASK) begin
               imask_reg <= wdata[2:0];
            end
            // a failed ending raises no completion event
            ist_reg[`CMTC_IRQ_DONE_BIT] <= any_ok |
               (ist_reg[`CMTC_IRQ_DONE_BIT] & ~(wr && addr == `CMTC_ADDR_IST && wdata[`CMTC_IRQ_DONE_BIT]));
            ist_reg[`CMTC_IRQ_ERR_BIT] <= any_bad |
               (ist_reg[`CMTC_IRQ_ERR_BIT] & ~(wr && addr == `CMTC_ADDR_IST && wdata[`CMTC_IRQ_ERR_BIT]));
            ist_reg[`CMTC_IRQ_ABT_BIT] <= any_abt |
               (ist_reg[`CMTC_IRQ_ABT_BIT] & ~(wr && addr == `CMTC_ADDR_IST && wdata[`CMTC_IRQ_ABT_BIT]));
         end
      end
   end

   // level interrupt from unmasked sticky bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(ist_reg & ~imask_reg);   // a set mask bit hides its source
      end
   end

   // shadow copy of the selected control byte; its read data is unused
   assign mem_we = 1'b1;
   assign mem_wd = '{abort_done: abt_reg[mbsel_reg], tx_done: done_reg[mbsel_reg],
                     single_attempt_enable: one_reg[mbsel_reg], rx_mailbox_select: rx_sel_reg[mbsel_reg],
                     tx_mailbox_select: tx_sel_reg[mbsel_reg]};

   cmtc_mb_mem #(.DEPTH(NUM_MB), .AW(AW)) u_mem (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .clr(in_reset),
      .we(mem_we),
      .waddr(mbsel_reg),
      .wdata(mem_wd),
      .raddr(mbsel_reg),
      .rdata(mem_rd)
   );

   // read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= '0;
         if (rd) begin
            case (addr)
               `CMTC_ADDR_CTRL: rdata <= ctrl_reg;
               `CMTC_ADDR_STAT: rdata <= {29'h0, active_reg, op_reg};
               `CMTC_ADDR_IST: rdata <= {29'h0, ist_reg};
               `CMTC_ADDR_IMASK: rdata <= {29'h0, imask_reg};
               `CMTC_ADDR_MBSEL: rdata <= 32'(mbsel_reg);
               `CMTC_ADDR_MBCTL: rdata <= {27'h0, abt_reg[mbsel_reg], done_reg[mbsel_reg], one_reg[mbsel_reg],
                                            rx_sel_reg[mbsel_reg], tx_sel_reg[mbsel_reg]};
               `CMTC_ADDR_DONE: rdata <= 32'(done_reg);
               `CMTC_ADDR_ABT: rdata <= 32'(abt_reg);
               `CMTC_ADDR_BUSY: rdata <= 32'(busy_reg);
               default: rdata <= '0;
            endcase
         end
      end
   end
endmodule
